// ===== hw/qdc_code_bank.sv
module qdc_code_bank (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   // write and update controls
   input wire logic [3:0] wr_en_in,
   input wire logic [15:0] wr_code_in,
   input wire logic [3:0] upd_en_in,
   input wire logic clr_in,
   input wire logic [15:0] clr_code_in,
   input wire logic preset_in,
   input wire logic [15:0] preset_code_in,
   // read port
   input wire logic [2:0] rd_sel_in,
   output logic [15:0] rd_data_out,
   // output codes, channel a in the low bits
   output logic [63:0] dac_code_out
);
   import qdc_pkg::*;

   logic [15:0] in_reg [NUM_CH];
   logic [15:0] dac_reg [NUM_CH];

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         for (int i = 0; i < NUM_CH; i++) begin
            in_reg[i] <= CODE_ZERO;
            dac_reg[i] <= CODE_ZERO;
         end
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (preset_in) begin
               in_reg[i] <= preset_code_in;
               dac_reg[i] <= preset_code_in;
            end else begin
               if (wr_en_in[i]) begin
                  in_reg[i] <= wr_code_in;
               end
               if (clr_in) begin
                  dac_reg[i] <= clr_code_in;
               end else if (upd_en_in[i]) begin
                  dac_reg[i] <= wr_en_in[i] ? wr_code_in : in_reg[i];
               end
            end
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         rd_data_out <= CODE_ZERO;
      end else begin
         rd_data_out <= rd_sel_in[2] ? in_reg[rd_sel_in[1:0]]
                                     : dac_reg[rd_sel_in[1:0]];
      end
   end

   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         dac_code_out[i*16 +: 16] = dac_reg[i];
      end
   end

   // clear pin overrides any load except a preset
   chk_clear_force: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in)
      clr_in && !preset_in |=> dac_reg[0] == $past(clr_code_in)
         && dac_reg[3] == $past(clr_code_in))
      else $error("clear did not force outputs");

   chk_load_copy: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in)
      upd_en_in == 4'hf && wr_en_in == 4'h0 && !clr_in && !preset_in
      |=> dac_reg[1] == $past(in_reg[1]))
      else $error("load strobe did not copy input");
endmodule : qdc_code_bank

// ===== hw/qdc_pkg.sv
package qdc_pkg;

   // --------------------------------------------------------------
   // serial frame layout
   // --------------------------------------------------------------
   localparam int unsigned FRAME_BITS = 32;
   localparam logic [5:0] BIT_CNT_LAST = 6'h1f;
   localparam int unsigned CMD_LSB = 24;
   localparam int unsigned ADDR_LSB = 20;
   localparam int unsigned CODE_LSB = 4;
   localparam int unsigned PD_MODE_LSB = 8;
   localparam int unsigned PD_CH_LSB = 0;
   localparam int unsigned CLR_SEL_LSB = 0;
   localparam int unsigned LOAD_OUTPUTS_N_MASK_LSB = 0;
   localparam int unsigned SETUP_REF_BIT = 0;
   localparam int unsigned SETUP_CHAIN_BIT = 1;
   localparam int unsigned NUM_CH = 4;

   // --------------------------------------------------------------
   // command and address codes
   // --------------------------------------------------------------
   localparam logic [3:0] CMD_WRITE_IN = 4'h0;
   localparam logic [3:0] CMD_UPDATE = 4'h1;
   localparam logic [3:0] CMD_WRITE_UPD_ALL = 4'h2;
   localparam logic [3:0] CMD_WRITE_UPD = 4'h3;
   localparam logic [3:0] CMD_POWER = 4'h4;
   localparam logic [3:0] CMD_CLR_CODE = 4'h5;
   localparam logic [3:0] CMD_LOAD_OUTPUTS_N_MASK = 4'h6;
   localparam logic [3:0] CMD_SOFT_RESET = 4'h7;
   localparam logic [3:0] CMD_SETUP = 4'h8;
   localparam logic [3:0] ADDR_ALL = 4'hf;
   localparam logic [3:0] ADDR_LAST_CH = 4'h3;
   localparam logic [1:0] CLR_SEL_NOP = 2'h3;

   // --------------------------------------------------------------
   // codes and reset values
   // --------------------------------------------------------------
   localparam logic [15:0] CODE_ZERO = 16'h0000;
   localparam logic [15:0] CODE_MID = 16'h8000;
   localparam logic [15:0] CODE_FULL = 16'hffff;
   localparam logic [7:0] PD_MODE_RST = 8'h00;
   localparam logic [3:0] LOAD_OUTPUTS_N_MASK_RST = 4'h0;
   localparam logic [1:0] SETUP_RST = 2'h0;
   localparam logic [1:0] INIT_DELAY = 2'h3;

   // --------------------------------------------------------------
   // register map
   // --------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_PWRDN = 8'h08;
   localparam logic [7:0] REG_CLRCODE = 8'h0c;
   localparam logic [7:0] REG_DAC_LO = 8'h10;
   localparam logic [7:0] REG_IN_HI = 8'h2c;
   localparam logic CTRL_PORT_EN_RST = 1'b1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // channel mask from the address field
   function automatic logic [3:0] chan_mask(input logic [3:0] addr);
      logic [3:0] m;
      m = 4'h0;
      if (addr == ADDR_ALL) begin
         m = 4'hf;
      end else if (addr <= ADDR_LAST_CH) begin
         m = 4'h1 << addr[1:0];
      end
      return m;
   endfunction : chan_mask

   function automatic logic [15:0] clear_value(input logic [1:0] sel);
      logic [15:0] v;
      v = CODE_ZERO;
      if (sel == 2'h1) begin
         v = CODE_MID;
      end else if (sel == 2'h2) begin
         v = CODE_FULL;
      end
      return v;
   endfunction : clear_value

endpackage : qdc_pkg

// ===== hw/qdc_serial_port.sv
module qdc_serial_port (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   // serial link
   input wire logic frame_select_n_in,
   input wire logic serial_clk_in,
   input wire logic serial_data_in,
   output logic chain_data_out,
   // control pins
   input wire logic load_outputs_n_in,
   input wire logic clear_outputs_n_in,
   input wire logic power_on_level_select_in,
   // axi4-lite write
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // converter controls
   output logic [63:0] dac_code_out,
   output logic [7:0] powerdown_mode_out,
   output logic reference_on_out,
   output logic chain_enable_out
);
   import qdc_pkg::*;

   typedef enum logic [1:0] {
      FR_WAIT_HIGH, FR_ARMED, FR_SHIFT, FR_DONE
   } qdc_frame_e;

   // --------------------------------------------------------------
   // pin synchronisers and edges
   // --------------------------------------------------------------
   logic [5:0] pins_s;
   logic sel_n_s, sclk_s, din_s, load_outputs_n_n_s, clr_n_s, por_s;
   logic sclk_prev;
   logic sclk_fall, sclk_rise;

   qdc_sync2 #(.W(6)) u_sync (
      .sys_clk_in(sys_clk_in),
      .sys_rst_in(sys_rst_in),
      .async_in({power_on_level_select_in, clear_outputs_n_in,
                 load_outputs_n_in, serial_data_in, serial_clk_in,
                 frame_select_n_in}),
      .sync_out(pins_s)
   );

   assign {por_s, clr_n_s, load_outputs_n_n_s, din_s, sclk_s, sel_n_s} = pins_s;

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         sclk_prev <= 1'b0;
      end else begin
         sclk_prev <= sclk_s;
      end
   end

   assign sclk_fall = sclk_prev && !sclk_s;
   assign sclk_rise = !sclk_prev && sclk_s;

   // --------------------------------------------------------------
   // frame sequencing
   // --------------------------------------------------------------
   qdc_frame_e state;
   logic [5:0] bit_cnt;
   logic [31:0] shift_reg;
   logic [31:0] next_word;
   logic exec;
   logic in_frame;
   logic port_en;

   assign next_word = {shift_reg[30:0], din_s};
   assign in_frame = (state == FR_SHIFT) || (state == FR_DONE);
   assign exec = (state == FR_SHIFT) && !sel_n_s && sclk_fall
                 && (bit_cnt == BIT_CNT_LAST);

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         state <= FR_WAIT_HIGH;
      end else begin
         case (state)
            FR_WAIT_HIGH: begin
               if (sel_n_s) begin
                  state <= FR_ARMED;
               end
            end
            FR_ARMED: begin
               if (!sel_n_s && port_en) begin
                  state <= FR_SHIFT;
               end
            end
            FR_SHIFT: begin
               if (sel_n_s) begin
                  state <= FR_ARMED;
               end else if (exec) begin
                  state <= FR_DONE;
               end
            end
            default: begin
               if (sel_n_s) begin
                  state <= FR_ARMED;
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in || state != FR_SHIFT) begin
         bit_cnt <= 6'h00;
      end else if (!sel_n_s && sclk_fall) begin
         bit_cnt <= bit_cnt + 6'h01;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         shift_reg <= 32'h0000_0000;
      end else if (state == FR_SHIFT && sel_n_s) begin
         shift_reg <= 32'h0000_0000;
      end else if (in_frame && !sel_n_s && sclk_fall) begin
         shift_reg <= next_word;
      end
   end

   // --------------------------------------------------------------
   // daisy chain output
   // --------------------------------------------------------------
   logic [1:0] setup;

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in || !setup[SETUP_CHAIN_BIT]) begin
         chain_data_out <= 1'b0;
      end else if (in_frame && !sel_n_s && sclk_rise) begin
         chain_data_out <= shift_reg[FRAME_BITS-1];
      end
   end

   // --------------------------------------------------------------
   // command decode
   // --------------------------------------------------------------
   logic [3:0] cmd, addr, sel, wr_en, upd_cmd, upd_en, load_outputs_n_mask;
   logic [15:0] code, clr_code, bank_rd;
   logic soft_reset, init_pulse;
   logic [1:0] init_cnt;

   assign cmd = next_word[CMD_LSB +: 4];
   assign addr = next_word[ADDR_LSB +: 4];
   assign code = next_word[CODE_LSB +: 16];
   assign sel = chan_mask(addr);

   always_comb begin
      wr_en = 4'h0;
      upd_cmd = 4'h0;
      if (exec) begin
         case (cmd)
            CMD_WRITE_IN: wr_en = sel;
            CMD_UPDATE: upd_cmd = sel;
            CMD_WRITE_UPD_ALL: begin
               wr_en = sel;
               upd_cmd = 4'hf;
            end
            CMD_WRITE_UPD: begin
               wr_en = sel;
               upd_cmd = sel;
            end
            default: begin
               wr_en = 4'h0;
               upd_cmd = 4'h0;
            end
         endcase
      end
   end

   assign upd_en = upd_cmd | (wr_en & load_outputs_n_mask)
                   | (load_outputs_n_n_s ? 4'h0 : 4'hf);
   assign soft_reset = (exec && cmd == CMD_SOFT_RESET) || init_pulse;

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         init_cnt <= INIT_DELAY;
      end else if (init_cnt != 2'h0) begin
         init_cnt <= init_cnt - 2'h1;
      end
   end
   assign init_pulse = (init_cnt == 2'h1);

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in || soft_reset) begin
         powerdown_mode_out <= PD_MODE_RST;
         clr_code <= CODE_ZERO;
         load_outputs_n_mask <= LOAD_OUTPUTS_N_MASK_RST;
         setup <= SETUP_RST;
      end else if (exec) begin
         case (cmd)
            CMD_POWER: begin
               for (int i = 0; i < NUM_CH; i++) begin
                  if (next_word[PD_CH_LSB + i]) begin
                     powerdown_mode_out[2*i +: 2] <=
                        next_word[PD_MODE_LSB +: 2];
                  end
               end
            end
            CMD_CLR_CODE: begin
               if (next_word[CLR_SEL_LSB +: 2] != CLR_SEL_NOP) begin
                  clr_code <= clear_value(next_word[CLR_SEL_LSB +: 2]);
               end
            end
            CMD_LOAD_OUTPUTS_N_MASK: load_outputs_n_mask <= next_word[LOAD_OUTPUTS_N_MASK_LSB +: 4];
            CMD_SETUP: setup <= next_word[1:0];
            default: setup <= setup;
         endcase
      end
   end

   assign reference_on_out = setup[SETUP_REF_BIT];
   assign chain_enable_out = setup[SETUP_CHAIN_BIT];

   qdc_code_bank u_bank (
      .sys_clk_in(sys_clk_in),
      .sys_rst_in(sys_rst_in),
      .wr_en_in(wr_en),
      .wr_code_in(code),
      .upd_en_in(upd_en),
      .clr_in(!clr_n_s),
      .clr_code_in(clr_code),
      .preset_in(soft_reset),
      .preset_code_in(por_s ? CODE_MID : CODE_ZERO),
      .rd_sel_in({s_axi_araddr_in[5], s_axi_araddr_in[3:2]}),
      .rd_data_out(bank_rd),
      .dac_code_out(dac_code_out)
   );

   // --------------------------------------------------------------
   // axi4-lite slave
   // --------------------------------------------------------------
   logic aw_held, w_held, ar_pend, wr_fire;
   logic [7:0] aw_addr, ar_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
   assign s_axi_wready_out = !w_held && !s_axi_bvalid_out;
   assign s_axi_arready_out = !ar_pend && !s_axi_rvalid_out;
   assign wr_fire = aw_held && w_held && !s_axi_bvalid_out;

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata_in;
            w_strb <= s_axi_wstrb_in;
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= (aw_addr[1:0] == 2'h0 &&
                                aw_addr <= REG_IN_HI)
                               ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         port_en <= CTRL_PORT_EN_RST;
      end else if (wr_fire && aw_addr == REG_CTRL && w_strb[0]) begin
         port_en <= w_data[0];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         ar_pend <= 1'b0;
         ar_addr <= 8'h00;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h0000_0000;
         s_axi_rresp_out <= RESP_OKAY;
      end else if (s_axi_arvalid_in && s_axi_arready_out) begin
         ar_pend <= 1'b1;
         ar_addr <= s_axi_araddr_in;
      end else if (ar_pend) begin
         ar_pend <= 1'b0;
         s_axi_rvalid_out <= 1'b1;
         s_axi_rresp_out <= RESP_OKAY;
         s_axi_rdata_out <= 32'h0000_0000;
         if (ar_addr[1:0] != 2'h0 || ar_addr > REG_IN_HI) begin
            s_axi_rresp_out <= RESP_SLVERR;
         end else if (ar_addr == REG_CTRL) begin
            s_axi_rdata_out <= {31'h0, port_en};
         end else if (ar_addr == REG_STATUS) begin
            s_axi_rdata_out <= {22'h0, !clr_n_s, !load_outputs_n_n_s, in_frame,
                                state == FR_ARMED, load_outputs_n_mask, setup};
         end else if (ar_addr == REG_PWRDN) begin
            s_axi_rdata_out <= {24'h0, powerdown_mode_out};
         end else if (ar_addr == REG_CLRCODE) begin
            s_axi_rdata_out <= {16'h0, clr_code};
         end else begin
            s_axi_rdata_out <= {16'h0, bank_rd};
         end
      end else if (s_axi_rready_in) begin
         s_axi_rvalid_out <= 1'b0;
      end
   end

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (sys_rst_in);

   sequence s_last_edge;
      state == FR_SHIFT && !sel_n_s && sclk_fall && bit_cnt == 6'h1f;
   endsequence

   chk_shift_falling: assert property (
      in_frame && !sel_n_s && sclk_fall |=> shift_reg == $past(next_word))
      else $error("bit not shifted on falling edge");
   chk_exec_32nd: assert property (
      exec |-> state == FR_SHIFT && bit_cnt == 6'h1f ##1 state == FR_DONE)
      else $error("execute not tied to 32nd edge");
   chk_frame_abort: assert property (
      state == FR_SHIFT && sel_n_s |-> !exec ##1
         shift_reg == 32'h0 && state == FR_ARMED)
      else $error("early rise did not discard frame");
   chk_ignore_high: assert property (
      sel_n_s && $past(sel_n_s) && $past(state) != FR_SHIFT
      |-> !exec && $stable(shift_reg))
      else $error("shift while select high");
   chk_chain_rise: assert property (
      setup[1] && in_frame && !sel_n_s && sclk_rise
      |=> chain_data_out == $past(shift_reg[31]))
      else $error("chain output not updated on rise");
   chk_chain_off: assert property (
      !$past(setup[1]) |-> !chain_data_out)
      else $error("chain output active in stand-alone");
   chk_reserved_nop: assert property (
      s_last_edge ##0 (cmd > CMD_SETUP) |=> $stable(setup)
         && $stable(powerdown_mode_out) && $stable(clr_code))
      else $error("reserved command changed state");
   chk_bad_addr: assert property (
      exec && addr != ADDR_ALL && addr > ADDR_LAST_CH |-> wr_en == 4'h0)
      else $error("undefined address wrote a channel");
endmodule : qdc_serial_port

// ===== hw/qdc_sync2.sv
module qdc_sync2 #(
   parameter int W = 6
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   // levels
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] stage1;

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule : qdc_sync2

// ===== tb/qdc_host_model.sv
module qdc_host_model (
   // clock
   input wire logic sys_clk_in,
   // serial link
   input wire logic chain_data_in,
   output logic frame_select_n_out,
   output logic serial_clk_out,
   output logic serial_data_out
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      frame_select_n_out = 1'b1;
      serial_clk_out = 1'b0;
      serial_data_out = 1'b0;
   end

   // ------------------------------------------------------------
   // one frame of nb bits, msb first, clock still outside frames
   // ------------------------------------------------------------
   task automatic frame(input logic [63:0] w, input int nb,
                        output logic [31:0] cap);
      cap = 32'h0;
      repeat (4) @(posedge sys_clk_in);
      frame_select_n_out <= 1'b0;
      for (int i = nb - 1; i >= 0; i--) begin
         @(posedge sys_clk_in);
         serial_clk_out <= 1'b1;
         serial_data_out <= w[i];
         repeat (4) @(posedge sys_clk_in);
         serial_clk_out <= 1'b0;
         repeat (3) @(posedge sys_clk_in);
         // chain bit read in low phase
         @(negedge sys_clk_in) cap = {cap[30:0], chain_data_in};
      end
      repeat (4) @(posedge sys_clk_in);
      frame_select_n_out <= 1'b1;
      serial_data_out <= ~serial_data_out;
      repeat (8) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
   endtask : frame
endmodule : qdc_host_model

// ===== tb/qdc_serial_port_tb.sv
module qdc_serial_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import qdc_pkg::*;
   logic clk, rst, fsn, sclk, sdi, chn, ldn, clrn, pol;
   logic [7:0] awa, ara;
   logic [31:0] wd, rd, q, cap;
   logic awv, awr, wv, wr_, bv, br, arv, arr, rv, rr, rf, ce;
   logic [1:0] bresp, rresp, r;
   logic [63:0] dac;
   logic [7:0] pdm;
   int fails, checks_done;

   qdc_host_model u_host (.sys_clk_in(clk), .chain_data_in(chn),
      .frame_select_n_out(fsn), .serial_clk_out(sclk),
      .serial_data_out(sdi));
   qdc_serial_port u_dut (.sys_clk_in(clk), .sys_rst_in(rst),
      .frame_select_n_in(fsn), .serial_clk_in(sclk),
      .serial_data_in(sdi), .chain_data_out(chn),
      .load_outputs_n_in(ldn), .clear_outputs_n_in(clrn),
      .power_on_level_select_in(pol), .s_axi_awaddr_in(awa),
      .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
      .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
      .s_axi_wready_out(wr_), .s_axi_bresp_out(bresp),
      .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
      .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
      .s_axi_arready_out(arr), .s_axi_rdata_out(rd),
      .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
      .s_axi_rready_in(rr), .dac_code_out(dac),
      .powerdown_mode_out(pdm), .reference_on_out(rf),
      .chain_enable_out(ce));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      logic ta, tw, tr, dn;
      dn = 1'b0;
      @(posedge clk);
      if (w) begin
         awa <= a;
         wd <= d;
         awv <= 1'b1;
         wv <= 1'b1;
         br <= 1'b1;
      end else begin
         ara <= a;
         arv <= 1'b1;
         rr <= 1'b1;
      end
      for (int n = 0; n < 100 && !dn; n++) begin
         @(negedge clk);
         ta = awv & awr;
         tw = wv & wr_;
         tr = arv & arr;
         dn = w ? bv : rv;
         q = rd;
         r = w ? bresp : rresp;
         @(posedge clk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
         if (tr) arv <= 1'b0;
         if (dn) br <= 1'b0;
         if (dn) rr <= 1'b0;
      end
      chk(64'(dn), 64'h1);
   endtask : bus

   task automatic cmd(input logic [3:0] c, input logic [3:0] a,
                      input logic [19:0] lo);
      u_host.frame({36'h0, c, a, lo}, 32, cap);
   endtask : cmd

   task automatic pin(input logic l, input logic c);
      @(posedge clk);
      ldn <= l;
      clrn <= c;
      repeat (6) @(posedge clk);
      @(negedge clk);
   endtask : pin

   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      test_done;
   end

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      {rst, ldn, clrn, pol} = 4'hf;
      {awv, wv, br, arv, rr, awa, ara, wd} = '0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      pin(1'b1, 1'b1);
      chk(dac, {4{CODE_MID}});
      chk(64'({ce, rf}), 64'(SETUP_RST));
      bus(1'b0, REG_CTRL, 32'h0);
      chk(64'(q), 64'(CTRL_PORT_EN_RST));
      bus(1'b0, 8'h30, 32'h0);
      chk(64'(r), 64'(RESP_SLVERR));
      cmd(CMD_WRITE_UPD, 4'h1, 20'h12340);
      chk(dac, {CODE_MID, CODE_MID, 16'h1234, CODE_MID});
      cmd(CMD_WRITE_IN, 4'h2, 20'habcd0);
      chk(dac, {CODE_MID, CODE_MID, 16'h1234, CODE_MID});
      bus(1'b0, REG_IN_HI - 8'h04, 32'h0);
      chk(64'(q), 64'h0000abcd);
      cmd(CMD_UPDATE, 4'h2, 20'h0);
      chk(dac, {CODE_MID, 16'habcd, 16'h1234, CODE_MID});
      u_host.frame({44'h0, 4'h0, CMD_WRITE_UPD, 12'h0}, 20, cap);
      chk(dac, {CODE_MID, 16'habcd, 16'h1234, CODE_MID});
      cmd(4'h9, 4'h0, 20'h0);
      chk(dac, {CODE_MID, 16'habcd, 16'h1234, CODE_MID});
      cmd(CMD_WRITE_UPD, 4'h5, 20'h0);
      chk(dac, {CODE_MID, 16'habcd, 16'h1234, CODE_MID});
      bus(1'b1, REG_CTRL, 32'h0);
      chk(64'(r), 64'(RESP_OKAY));
      cmd(CMD_WRITE_UPD, ADDR_ALL, 20'h99990);
      chk(dac, {CODE_MID, 16'habcd, 16'h1234, CODE_MID});
      bus(1'b1, REG_CTRL, 32'h1);
      cmd(CMD_WRITE_UPD_ALL, 4'h0, 20'h55550);
      chk(dac, {CODE_MID, 16'habcd, 16'h1234, 16'h5555});
      cmd(CMD_WRITE_UPD, ADDR_ALL, 20'h0f0f0);
      chk(dac, {4{16'h0f0f}});
      cmd(CMD_POWER, 4'h0, 20'h00205);
      chk(64'(pdm), 64'h22);
      bus(1'b0, REG_PWRDN, 32'h0);
      chk(64'(q), 64'h22);
      cmd(CMD_CLR_CODE, 4'h0, 20'h2);
      bus(1'b0, REG_CLRCODE, 32'h0);
      chk(64'(q), 64'(CODE_FULL));
      pin(1'b1, 1'b0);
      chk(dac, {4{CODE_FULL}});
      pin(1'b1, 1'b1);
      cmd(CMD_WRITE_IN, 4'h0, 20'h11110);
      chk(dac, {4{CODE_FULL}});
      pin(1'b0, 1'b1);
      pin(1'b1, 1'b1);
      chk(dac, {{3{16'h0f0f}}, 16'h1111});
      bus(1'b0, REG_DAC_LO, 32'h0);
      chk(64'(q), 64'h1111);
      cmd(CMD_LOAD_OUTPUTS_N_MASK, 4'h0, 20'h1);
      cmd(CMD_WRITE_IN, 4'h0, 20'h77770);
      chk(dac, {{3{16'h0f0f}}, 16'h7777});
      cmd(CMD_SETUP, 4'h0, 20'h3);
      chk(64'({ce, rf}), 64'h3);
      bus(1'b0, REG_STATUS, 32'h0);
      chk(64'(q), 64'h47);
      u_host.frame(64'h03124680_c3c35a5a, 64, cap);
      chk(64'(cap), 64'h03124680);
      chk(dac, {16'h0f0f, 16'h0f0f, 16'h2468, 16'h7777});
      cmd(CMD_SOFT_RESET, 4'h0, 20'h0);
      chk(dac, {4{CODE_MID}});
      chk(64'({pdm, ce, rf}), 64'h0);
      test_done;
   end
endmodule : qdc_serial_port_tb
